/* sbh_pkg.sv */
// Constants and types for the serial bus function header register slice
package sbh_pkg;

    // ------------------------------------------------------------
    // Configuration offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] SBH_OFF_HDR_DW   = 8'h0c;
    localparam logic [7:0] SBH_OFF_HDR      = 8'h0e;
    localparam logic [7:0] SBH_OFF_HOST_BAR = 8'h10;
    localparam logic [7:0] SBH_OFF_VEND_BAR = 8'h14;
    localparam logic [7:0] SBH_OFF_SUBSYS   = 8'h2c;
    localparam logic [7:0] SBH_OFF_CAP_PTR  = 8'h34;
    localparam logic [7:0] SBH_OFF_PM_CAP   = 8'h44;
    localparam logic [7:0] SBH_OFF_PM_CTRL  = 8'h48;

    // ------------------------------------------------------------
    // Field positions and fixed values
    // ------------------------------------------------------------
    localparam int         SBH_HDR_LANE_LSB  = 16;
    localparam logic [7:0] SBH_SELF_TEST_VAL = 8'h00;
    localparam logic [7:0] SBH_HDR_KIND_VAL  = 8'h00;
    localparam logic [7:0] SBH_CAP_PTR_VAL   = SBH_OFF_PM_CAP;

    localparam int SBH_HOST_PTR_LSB = 11;
    localparam int SBH_HOST_PTR_W   = 21;
    localparam int SBH_VEND_PTR_LSB = 14;
    localparam int SBH_VEND_PTR_W   = 18;

    localparam logic       SBH_PREFETCH_VAL = 1'b0;
    localparam logic [1:0] SBH_DECODE_VAL   = 2'h0;
    localparam logic       SBH_SPACE_VAL    = 1'b0;

    localparam logic [31:0] SBH_HOST_WR_MASK = 32'hffff_f800;
    localparam logic [31:0] SBH_VEND_WR_MASK = 32'hffff_c000;
    localparam logic [31:0] SBH_BAR_RESET    = 32'h0000_0000;
    localparam logic [31:0] SBH_READ_ZERO    = 32'h0000_0000;

    localparam int SBH_SS_DEV_LSB = 16;
    localparam int SBH_SS_VEN_LSB = 0;

    // ------------------------------------------------------------
    // State types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [SBH_HOST_PTR_W-1:0] host_ptr;
        logic [SBH_VEND_PTR_W-1:0] vend_ptr;
        logic [31:0]               rdata;
        logic                      ack;
        logic                      pm_hit;
        logic                      host_hit;
        logic                      vend_hit;
    } sbh_top_state_t;

    typedef struct packed {
        logic [15:0] dev_code;
        logic [15:0] ven_code;
    } sbh_ss_state_t;

endpackage : sbh_pkg

/* sbh_ss_if.sv */
// Carrier between the header slice and its subsystem identity store
`timescale 1ns/10ps
interface sbh_ss_if;
    logic        load;
    logic [31:0] load_data;
    logic [15:0] dev_code;
    logic [15:0] ven_code;

    modport ctrl  (output load, output load_data, input dev_code, input ven_code);
    modport store (input load, input load_data, output dev_code, output ven_code);
endinterface : sbh_ss_if

/* sbh_subsys_store.sv */
// Subsystem identity store, cleared only by the global reset
`timescale 1ns/10ps
module sbh_subsys_store (
    input wire logic clk,            // Function clock
    input wire logic global_reset_n, // Global reset, the only clear
    sbh_ss_if.store  ss              // Load request and stored codes
);
    import sbh_pkg::*;

    sbh_ss_state_t q;
    sbh_ss_state_t d;

    always_comb begin
        d = q;
        if (ss.load) begin
            d.dev_code = ss.load_data[SBH_SS_DEV_LSB +: 16]; // [RQ11]
            d.ven_code = ss.load_data[SBH_SS_VEN_LSB +: 16]; // [RQ11]
        end
    end

    // Function reset is not wired here on purpose: codes survive it
    always_ff @(posedge clk or negedge global_reset_n) begin
        if (!global_reset_n) begin
            q <= '0; // [RQ12]
        end else begin
            q <= d;
        end
    end

    assign ss.dev_code = q.dev_code;
    assign ss.ven_code = q.ven_code;

endmodule : sbh_subsys_store

/* sbh_header_slice.sv */
// Configuration header slice 0Eh..34h of the serial bus function
//
// Operation
// [RQ1] Self-test byte always reads zero
// [RQ2] Header kind byte always reads zero
// [RQ3] Host window base: bits 31..11 writable, reset zero
// [RQ4] All-ones write reads back 2K sizing pattern
// [RQ5] Host window bits 10..4 read zero
// [RQ6] Host window bits 3..0 read zero
// [RQ7] Vendor window base: bits 31..14 writable, reset zero
// [RQ8] All-ones write reads back 16K sizing pattern
// [RQ9] Vendor window bits 13..0 read zero
// [RQ10] Subsystem identity ignores writes; loaded by loaders
// [RQ11] Device code high half, vendor code low
// [RQ12] Subsystem codes cleared only by global reset
// [RQ13] Capability pointer read-only, returns 44h
// [RQ14] Power capability at 44h and 48h
// [RQ15] Host sizes windows, then programs aligned base
// [RQ16] Writes honour byte enables, keep read-only bits
`timescale 1ns/10ps
module sbh_header_slice (
    input  wire logic        clk,                // Function clock
    input  wire logic        resetn,             // Function reset, async, low
    input  wire logic        global_reset_n,     // Global reset, async, low

    input  wire logic        cfg_req,            // Configuration access request
    input  wire logic        cfg_write,          // 1 write, 0 read
    input  wire logic [7:0]  cfg_addr,           // Configuration byte offset
    input  wire logic [3:0]  cfg_byte_en,        // Byte lane enables, high
    input  wire logic [31:0] cfg_wdata,          // Write data
    output logic      [31:0] cfg_rdata,          // Read data
    output logic             cfg_ack,            // Access done, one cycle
    output logic             cfg_pm_hit,         // Access belongs to power block

    input  wire logic        eeprom_ss_valid,    // Serial loader has identity
    input  wire logic [31:0] eeprom_ss_data,     // Identity from serial loader
    input  wire logic        access_ss_valid,    // Access register write
    input  wire logic [31:0] access_ss_data,     // Identity from access register

    input  wire logic        mem_space_en,       // Memory space decoding on
    input  wire logic        mem_addr_valid,     // Memory address present
    input  wire logic [31:0] mem_addr,           // Memory address to decode
    output logic             host_window_hit,    // Address in host window
    output logic             vendor_window_hit,  // Address in vendor window
    output logic      [31:0] host_window_base,   // Host window base view
    output logic      [31:0] vendor_window_base  // Vendor window base view
);
    import sbh_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Byte-lane merge of a write into the writable bits only
    function automatic logic [31:0] merge_write(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0]  lanes,
        input logic [31:0] wr_mask
    );
        logic [31:0] lane_mask;
        logic [31:0] eff_mask;
        lane_mask = {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}};
        eff_mask  = lane_mask & wr_mask; // [RQ16]
        merge_write = (old_val & ~eff_mask) | (new_val & eff_mask); // [RQ16]
    endfunction : merge_write

    // Full view of the host window base register
    function automatic logic [31:0] host_view(
        input logic [SBH_HOST_PTR_W-1:0] ptr
    );
        logic [6:0] size_bits;
        size_bits = 7'h00; // [RQ5]
        host_view = {ptr,
                     size_bits,
                     SBH_PREFETCH_VAL, // [RQ6]
                     SBH_DECODE_VAL,   // [RQ6]
                     SBH_SPACE_VAL};   // [RQ6]
    endfunction : host_view

    // Full view of the vendor window base register
    function automatic logic [31:0] vend_view(
        input logic [SBH_VEND_PTR_W-1:0] ptr
    );
        logic [9:0] size_bits;
        size_bits = 10'h000; // [RQ9]
        vend_view = {ptr,
                     size_bits,
                     SBH_PREFETCH_VAL, // [RQ9]
                     SBH_DECODE_VAL,   // [RQ9]
                     SBH_SPACE_VAL};   // [RQ9]
    endfunction : vend_view

    // ------------------------------------------------------------
    // Subsystem identity store
    // ------------------------------------------------------------
    sbh_ss_if ss_bus ();

    // Serial loader runs after global reset, so it takes precedence
    assign ss_bus.load      = eeprom_ss_valid | access_ss_valid; // [RQ10]
    assign ss_bus.load_data = eeprom_ss_valid ? eeprom_ss_data
                                              : access_ss_data; // [RQ10]

    sbh_subsys_store u_subsys_store (
        .clk            (clk),
        .global_reset_n (global_reset_n),
        .ss             (ss_bus.store)
    );

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic [5:0] dw_idx;
    logic       sel_hdr;
    logic       sel_host;
    logic       sel_vend;
    logic       sel_ss;
    logic       sel_cap;
    logic       sel_pm;

    assign dw_idx   = cfg_addr[7:2];
    assign sel_hdr  = (dw_idx == SBH_OFF_HDR_DW[7:2]);
    assign sel_host = (dw_idx == SBH_OFF_HOST_BAR[7:2]);
    assign sel_vend = (dw_idx == SBH_OFF_VEND_BAR[7:2]);
    assign sel_ss   = (dw_idx == SBH_OFF_SUBSYS[7:2]);
    assign sel_cap  = (dw_idx == SBH_OFF_CAP_PTR[7:2]);
    assign sel_pm   = (dw_idx == SBH_OFF_PM_CAP[7:2]) ||
                      (dw_idx == SBH_OFF_PM_CTRL[7:2]); // [RQ14]

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [31:0] hdr_word;
    logic [31:0] ss_word;
    logic [31:0] cap_word;
    logic [31:0] rd_mux;

    // Low half of the 0Ch dword belongs to the latency/cache block
    always_comb begin
        hdr_word = SBH_READ_ZERO;
        hdr_word[SBH_HDR_LANE_LSB +: 8]     = SBH_HDR_KIND_VAL;  // [RQ2]
        hdr_word[SBH_HDR_LANE_LSB + 8 +: 8] = SBH_SELF_TEST_VAL; // [RQ1]
    end

    always_comb begin
        ss_word = SBH_READ_ZERO;
        ss_word[SBH_SS_DEV_LSB +: 16] = ss_bus.dev_code; // [RQ11]
        ss_word[SBH_SS_VEN_LSB +: 16] = ss_bus.ven_code; // [RQ11]
    end

    always_comb begin
        cap_word      = SBH_READ_ZERO;
        cap_word[7:0] = SBH_CAP_PTR_VAL; // [RQ13]
    end

    sbh_top_state_t q;
    sbh_top_state_t d;

    logic [31:0] host_word;
    logic [31:0] vend_word;

    always_comb begin
        host_word = host_view(q.host_ptr);
        vend_word = vend_view(q.vend_ptr);
    end

    // Offsets outside this slice read zero; other blocks OR theirs in
    always_comb begin
        rd_mux = SBH_READ_ZERO;
        if (sel_hdr) begin
            rd_mux = hdr_word;
        end else if (sel_host) begin
            rd_mux = host_word; // [RQ4]
        end else if (sel_vend) begin
            rd_mux = vend_word; // [RQ8]
        end else if (sel_ss) begin
            rd_mux = ss_word;
        end else if (sel_cap) begin
            rd_mux = cap_word;
        end
    end

    // ------------------------------------------------------------
    // Window base write path
    // ------------------------------------------------------------
    logic [31:0] host_merged;
    logic [31:0] vend_merged;
    logic        wr_host;
    logic        wr_vend;

    assign wr_host = cfg_req && cfg_write && sel_host;
    assign wr_vend = cfg_req && cfg_write && sel_vend;

    always_comb begin
        host_merged = merge_write(host_word, cfg_wdata, cfg_byte_en,
                                  SBH_HOST_WR_MASK); // [RQ3]
        vend_merged = merge_write(vend_word, cfg_wdata, cfg_byte_en,
                                  SBH_VEND_WR_MASK); // [RQ7]
    end

    // ------------------------------------------------------------
    // Memory window decode
    // ------------------------------------------------------------
    logic host_match;
    logic vend_match;

    // A window at base zero is legal, so decode relies on mem_space_en
    assign host_match = mem_space_en && mem_addr_valid &&
                        (mem_addr[31:SBH_HOST_PTR_LSB] == q.host_ptr);
    assign vend_match = mem_space_en && mem_addr_valid &&
                        (mem_addr[31:SBH_VEND_PTR_LSB] == q.vend_ptr);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    always_comb begin
        d          = q;
        d.ack      = cfg_req;
        d.pm_hit   = cfg_req && sel_pm; // [RQ14]
        d.host_hit = host_match;
        d.vend_hit = vend_match;
        d.rdata    = SBH_READ_ZERO;
        if (cfg_req && !cfg_write) begin
            d.rdata = rd_mux;
        end
        if (wr_host) begin
            d.host_ptr = host_merged[31:SBH_HOST_PTR_LSB]; // [RQ3]
        end
        if (wr_vend) begin
            d.vend_ptr = vend_merged[31:SBH_VEND_PTR_LSB]; // [RQ7]
        end
        // Writes to header, identity and pointer dwords are dropped
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q          <= '0;
            q.host_ptr <= SBH_BAR_RESET[31:SBH_HOST_PTR_LSB]; // [RQ3]
            q.vend_ptr <= SBH_BAR_RESET[31:SBH_VEND_PTR_LSB]; // [RQ7]
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign cfg_rdata          = q.rdata;
    assign cfg_ack            = q.ack;
    assign cfg_pm_hit         = q.pm_hit;
    assign host_window_hit    = q.host_hit;
    assign vendor_window_hit  = q.vend_hit;
    assign host_window_base   = {q.host_ptr, 11'h000}; // [RQ6]
    assign vendor_window_base = {q.vend_ptr, 14'h0000}; // [RQ9]

endmodule : sbh_header_slice

/* sbh_header_props.sv */
// Port assertions for the configuration header slice
`timescale 1ns/10ps
module sbh_header_props (
    input wire logic        clk,              // Function clock
    input wire logic        resetn,           // Function reset
    input wire logic        cfg_req,          // Access request
    input wire logic        cfg_write,        // Write flag
    input wire logic [7:0]  cfg_addr,         // Byte offset
    input wire logic [3:0]  cfg_byte_en,      // Lane enables
    input wire logic [31:0] cfg_wdata,        // Write data
    input wire logic [31:0] cfg_rdata,        // Read data
    input wire logic        cfg_ack,          // Access done
    input wire logic        cfg_pm_hit,       // Power block access
    input wire logic [31:0] host_window_base, // Host base view
    input wire logic [31:0] vendor_window_base // Vendor base view
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // ----
    // Access timing and fixed fields
    // ----
    a_ack_follows: assert property (cfg_req |=> cfg_ack) else $error("ack missing");
    a_ack_spurious: assert property (!cfg_req |=> !cfg_ack) else $error("ack without request");
    a_hdr_zero: assert property (cfg_req && !cfg_write && cfg_addr[7:2] == 6'h03
        |=> cfg_rdata[31:16] == 16'h0000) else $error("header byte not zero");
    a_cap_ptr: assert property (cfg_req && !cfg_write && cfg_addr[7:2] == 6'h0d
        |=> cfg_rdata == 32'h0000_0044) else $error("capability pointer wrong");
    a_host_low: assert property (cfg_req && !cfg_write && cfg_addr[7:2] == 6'h04
        |=> cfg_rdata[10:0] == 11'h000) else $error("host low bits set");
    a_vend_low: assert property (cfg_req && !cfg_write && cfg_addr[7:2] == 6'h05
        |=> cfg_rdata[13:0] == 14'h0000) else $error("vendor low bits set");
    a_pm_flag: assert property (cfg_req && cfg_addr[7:3] == 5'h08 && cfg_addr[2]
        ##1 cfg_ack |-> cfg_pm_hit) else $error("power block not flagged");
    a_pm_ctrl: assert property (cfg_req && cfg_addr[7:2] == 6'h12 |=> cfg_pm_hit)
        else $error("power control dword not flagged");
    a_pm_quiet: assert property (cfg_req && cfg_addr[7:2] != 6'h11 && cfg_addr[7:2] != 6'h12
        |=> !cfg_pm_hit) else $error("power flag on foreign access");
    // ----
    // Base register updates
    // ----
    a_host_write: assert property (cfg_req && cfg_write && cfg_addr[7:2] == 6'h04
        && cfg_byte_en == 4'hf |=> host_window_base == ($past(cfg_wdata) & 32'hffff_f800))
        else $error("host base write wrong");
    a_vend_write: assert property (cfg_req && cfg_write && cfg_addr[7:2] == 6'h05
        && cfg_byte_en == 4'hf |=> vendor_window_base == ($past(cfg_wdata) & 32'hffff_c000))
        else $error("vendor base write wrong");
endmodule : sbh_header_props

bind sbh_header_slice sbh_header_props i_sbh_header_props (.clk(clk), .resetn(resetn),
    .cfg_req(cfg_req), .cfg_write(cfg_write), .cfg_addr(cfg_addr),
    .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_ack(cfg_ack), .cfg_pm_hit(cfg_pm_hit), .host_window_base(host_window_base),
    .vendor_window_base(vendor_window_base));

/* sbh_host_model.sv */
// Host bridge model issuing configuration cycles
`timescale 1ns/10ps
module sbh_host_model (
    input wire logic        clk,         // Function clock
    output logic            cfg_req,     // Access request
    output logic            cfg_write,   // Write flag
    output logic     [7:0]  cfg_addr,    // Byte offset
    output logic     [3:0]  cfg_byte_en, // Lane enables
    output logic     [31:0] cfg_wdata,   // Write data
    input wire logic [31:0] cfg_rdata,   // Read data
    input wire logic        cfg_ack      // Access done
);
    initial begin
        cfg_req = 1'b0;
        cfg_write = 1'b0;
        cfg_addr = 8'h00;
        cfg_byte_en = 4'h0;
        cfg_wdata = 32'h0000_0000;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] be,
                        input logic [31:0] wd, output logic [31:0] rd);
        int n;
        @(posedge clk);
        cfg_req <= 1'b1;
        cfg_write <= w;
        cfg_addr <= a;
        cfg_byte_en <= be;
        cfg_wdata <= wd;
        @(posedge clk);
        cfg_req <= 1'b0;
        cfg_byte_en <= 4'h0;
        // Released data must not look valid
        cfg_wdata <= ~wd;
        #1;
        n = 0;
        while (cfg_ack !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        rd = (n < 4) ? cfg_rdata : 32'hxxxx_xxxx;
    endtask : xfer
    // Window sizing: all ones, read back, then an aligned base
    task automatic size_window(input logic [7:0] a, input logic [31:0] base,
                               output logic [31:0] sz);
        logic [31:0] d;
        xfer(1'b1, a, 4'hf, 32'hffff_ffff, d);
        xfer(1'b0, a, 4'h0, 32'h0000_0000, sz);
        xfer(1'b1, a, 4'hf, base & sz, d);
    endtask : size_window
endmodule : sbh_host_model

/* testbench.sv */
// Self-checking bench for the configuration header slice
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
    $display("Error %0t: got %h exp %h", $time, g, e); end end
module testbench;
    import sbh_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, global_reset_n = 1'b0;
    logic ee_v = 1'b0, ac_v = 1'b0, ms_en = 1'b0, ma_v = 1'b0;
    logic [31:0] ee_d = 32'h0000_0000, ac_d = 32'h0000_0000, ma = 32'h0000_0000;
    logic cfg_req, cfg_write, cfg_ack, cfg_pm_hit, h_hit, v_hit;
    logic [7:0] cfg_addr;
    logic [3:0] cfg_byte_en;
    logic [31:0] cfg_wdata, cfg_rdata, d;
    int err_total = 0, checks = 0, cycles = 0;
    always #2 clk = ~clk;
    sbh_host_model i_sbh_host_model (.clk(clk), .cfg_req(cfg_req), .cfg_write(cfg_write),
        .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack));
    sbh_header_slice i_sbh_header_slice (.clk(clk), .resetn(resetn),
        .global_reset_n(global_reset_n), .cfg_req(cfg_req), .cfg_write(cfg_write),
        .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .cfg_pm_hit(cfg_pm_hit),
        .eeprom_ss_valid(ee_v), .eeprom_ss_data(ee_d), .access_ss_valid(ac_v),
        .access_ss_data(ac_d), .mem_space_en(ms_en), .mem_addr_valid(ma_v), .mem_addr(ma),
        .host_window_hit(h_hit), .vendor_window_hit(v_hit), .host_window_base(),
        .vendor_window_base());
    task automatic tally_and_finish();
        if (err_total == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    // Hang guard, well above the fewer than one hundred cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            tally_and_finish();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] v);
        logic [31:0] x;
        i_sbh_host_model.xfer(1'b1, a, be, v, x);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        i_sbh_host_model.xfer(1'b0, a, 4'h0, 32'h0000_0000, x);
        `CHK(x, e)
    endtask : rd_chk
    task automatic ss_load(input logic ev, input logic av, input logic [31:0] ed, ad);
        @(posedge clk);
        ee_v <= ev;
        ac_v <= av;
        ee_d <= ed;
        ac_d <= ad;
        @(posedge clk);
        ee_v <= 1'b0;
        ac_v <= 1'b0;
        ee_d <= ~ed;
        ac_d <= ~ad;
    endtask : ss_load
    task automatic pulse(input logic g);
        @(posedge clk);
        resetn <= 1'b0;
        global_reset_n <= ~g;
        @(posedge clk);
        resetn <= 1'b1;
        global_reset_n <= 1'b1;
    endtask : pulse
    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        global_reset_n <= 1'b1;
        rd_chk(8'h10, 32'h0000_0000);
        rd_chk(8'h14, 32'h0000_0000);
        wr(8'h0c, 4'hf, 32'hffff_ffff);
        rd_chk(8'h0c, 32'h0000_0000);
        wr(8'h34, 4'hf, 32'hffff_ffff);
        rd_chk(8'h34, 32'h0000_0044);
        `CHK(cfg_pm_hit, 1'b0)
        wr(8'h48, 4'hf, 32'hffff_ffff);
        rd_chk(8'h44, 32'h0000_0000);
        `CHK(cfg_pm_hit, 1'b1)
        rd_chk(8'h48, 32'h0000_0000);
        `CHK(cfg_pm_hit, 1'b1)
        i_sbh_host_model.size_window(8'h10, 32'h8000_0000, d);
        `CHK(d, 32'hffff_f800)
        rd_chk(8'h10, 32'h8000_0000);
        i_sbh_host_model.size_window(8'h14, 32'h9000_4000, d);
        `CHK(d, 32'hffff_c000)
        rd_chk(8'h14, 32'h9000_4000);
        wr(8'h10, 4'b0100, 32'h1234_5678);
        rd_chk(8'h10, 32'h8034_0000);
        wr(8'h10, 4'b0010, 32'hffff_ffff);
        rd_chk(8'h10, 32'h8034_f800);
        @(posedge clk);
        ms_en <= 1'b1;
        ma_v <= 1'b1;
        ma <= 32'h8034_f9a0;
        @(posedge clk);
        ma_v <= 1'b0;
        #1;
        `CHK(h_hit, 1'b1)
        `CHK(v_hit, 1'b0)
        @(posedge clk);
        ma_v <= 1'b1;
        ma <= 32'h9000_7ffc;
        @(posedge clk);
        ms_en <= 1'b0;
        #1;
        `CHK(h_hit, 1'b0)
        `CHK(v_hit, 1'b1)
        @(posedge clk);
        ma_v <= 1'b0;
        #1;
        `CHK(v_hit, 1'b0)
        ss_load(1'b1, 1'b0, 32'h5a5a_0001, 32'h0000_0000);
        rd_chk(8'h2c, 32'h5a5a_0001);
        wr(8'h2c, 4'hf, 32'hffff_ffff);
        rd_chk(8'h2c, 32'h5a5a_0001);
        ss_load(1'b0, 1'b1, 32'h0000_0000, 32'h0002_0003);
        rd_chk(8'h2c, 32'h0002_0003);
        ss_load(1'b1, 1'b1, 32'h0a0b_0c0d, 32'h1111_2222);
        rd_chk(8'h2c, 32'h0a0b_0c0d);
        pulse(1'b0);
        rd_chk(8'h2c, 32'h0a0b_0c0d);
        rd_chk(8'h10, 32'h0000_0000);
        rd_chk(8'h14, 32'h0000_0000);
        pulse(1'b1);
        rd_chk(8'h2c, 32'h0000_0000);
        tally_and_finish();
    end
endmodule : testbench
